// file: asu_pkg.sv
// package for the async serial unit registers, status bits, rate dividers and interrupt events
package asu_pkg;
	// register indices and bus address width (printed offsets are not multiples of four)
	localparam logic [7:0] IDX_STATUS = 8'h50;
	localparam logic [7:0] IDX_DATA   = 8'h51;
	localparam logic [7:0] IDX_BAUD   = 8'h52;
	localparam logic [7:0] IDX_CTL1   = 8'h53;
	localparam logic [7:0] IDX_CTL2   = 8'h54;
	localparam logic [7:0] IDX_ERX    = 8'h55;
	localparam logic [7:0] IDX_ETX    = 8'h56;
	localparam logic [7:0] IDX_IRQ_EN  = 8'h57;
	localparam logic [7:0] IDX_IRQ_ST  = 8'h58;
	localparam logic [7:0] IDX_IRQ_CLR = 8'h59;
	localparam logic [7:0] IDX_RX_IN   = 8'h5a;
	localparam int         ADDR_W     = 10;
	// reset values
	localparam logic [7:0] STATUS_RST = 8'hc0;
	localparam logic [7:0] ZERO_RST   = 8'h00;
	// status bit positions
	localparam int ST_TXE  = 7;
	localparam int ST_TC   = 6;
	localparam int ST_RXF  = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OR   = 3;
	localparam int ST_NF   = 2;
	localparam int ST_FE   = 1;
	// field positions of the baud register, and the ninth-bit position in CTL1
	localparam int FS_LSB = 6;
	localparam int TX_LSB = 3;
	localparam int RX_LSB = 0;
	localparam int CTL1_R9 = 7;
	// fixed divide stage
	localparam int           FIXED_DIV = 16;
	localparam logic [3:0]   FIXED_MAX = 4'(FIXED_DIV - 1);
	// first stage factors minus one
	localparam logic [3:0] FS_F0 = 4'h0;
	localparam logic [3:0] FS_F1 = 4'h2;
	localparam logic [3:0] FS_F2 = 4'h3;
	localparam logic [3:0] FS_F3 = 4'hc;
	// interrupt event bits
	localparam int EV_RX   = 0;
	localparam int EV_TXE  = 1;
	localparam int EV_TC   = 2;
	localparam int EV_OR   = 3;
	localparam int EV_IDLE = 4;
	localparam int EV_W    = 5;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       ninth;
		logic       noise;
		logic       frame;
		logic       idle;
	} asu_rx_t;

	typedef enum logic [1:0] {
		ASU_IDLE = 2'b00,
		ASU_ACK  = 2'b01
	} asu_bus_t;
endpackage

// file: asu_regs.sv
// async serial unit: data stores, rate dividers and register file
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
module asu_regs
	import asu_pkg::*;
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// wishbone slave
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output logic      [31:0]      dat_o,
	output logic                  ack_o,
	// outgoing shifter side
	output logic      [7:0]       tx_data_o,
	output logic                  tx_valid_o,
	input  wire logic             tx_take_i,
	input  wire logic             tx_done_i,
	// incoming shifter side
	input  wire asu_rx_t          rx_i,
	// rate ticks, one per bit period, taken after the fixed divide by 16
	output logic                  tx_tick_o,
	output logic                  rx_tick_o,
	// interrupt
	output logic                  irq_o
);
	// ************************************************************
	// bus decode
	// ************************************************************
	logic [7:0] idx;
	logic       req;
	logic       wr;
	logic       rd;
	asu_bus_t   bus_r;
	assign idx = adr_i[ADDR_W-1:2];
	assign req = cyc_i && stb_i && !ack_o && bus_r == ASU_IDLE;
	assign wr  = req && we_i && sel_i[0];
	assign rd  = req && !we_i;

	// ************************************************************
	// per-register strobes
	// ************************************************************
	logic hit_status;
	logic hit_data;
	logic hit_baud;
	logic hit_ctl1;
	logic hit_ctl2;
	logic hit_erx;
	logic hit_etx;
	logic hit_irq_en;
	assign hit_status = idx == IDX_STATUS;
	assign hit_data   = idx == IDX_DATA;
	assign hit_baud   = idx == IDX_BAUD;
	assign hit_ctl1   = idx == IDX_CTL1;
	assign hit_ctl2   = idx == IDX_CTL2;
	assign hit_erx    = idx == IDX_ERX;
	assign hit_etx    = idx == IDX_ETX;
	assign hit_irq_en = idx == IDX_IRQ_EN;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_r <= ASU_IDLE;
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
			case (bus_r)
				ASU_IDLE: bus_r <= req ? ASU_ACK : ASU_IDLE;
				ASU_ACK:  bus_r <= ASU_IDLE;
				default:  bus_r <= ASU_IDLE;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] status;
	logic       txe_r;
	logic       tc_r;
	logic       rxf_r;
	logic       idle_r;
	logic       ovr_r;
	logic       nf_r;
	logic       fe_r;
	logic       rx_load;
	logic       rx_over;
	logic [7:0] tx_store_r;
	logic [7:0] rx_store_r;
	logic [7:0] baud_r;
	logic [7:0] ctl1_r;
	logic [7:0] ctl2_r;
	logic [7:0] erx_r;
	logic [7:0] etx_r;
	logic [EV_W-1:0] irq_en_r;
	logic [EV_W-1:0] irq_st_r;
	logic       armed_r;
	logic       tx_pend_r;
	logic [EV_W-1:0] ev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_r <= ZERO_RST;
		end else if (wr && hit_baud) begin
			baud_r <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			erx_r <= ZERO_RST;
		end else if (wr && hit_erx) begin
			erx_r <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			etx_r <= ZERO_RST;
		end else if (wr && hit_etx) begin
			etx_r <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl2_r <= ZERO_RST;
		end else if (wr && hit_ctl2) begin
			ctl2_r <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_r <= '0;
		end else if (wr && hit_irq_en) begin
			irq_en_r <= dat_i[EV_W-1:0];
		end
	end

	// bit 7 follows the stored character, so software cannot write it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl1_r <= ZERO_RST;
		end else begin
			if (wr && hit_ctl1) begin
				ctl1_r[CTL1_R9-1:0] <= dat_i[CTL1_R9-1:0];
			end
			if (rx_load) begin
				ctl1_r[CTL1_R9] <= rx_i.ninth;
			end
		end
	end

	// two separate stores; no reset, content undefined until used
	always_ff @(posedge clk_i) begin
		if (wr && idx == IDX_DATA) tx_store_r <= dat_i[7:0];
		if (rx_load) rx_store_r <= rx_i.data;
	end

	// transmit hand-off to the shifter
	always_ff @(posedge clk_i) begin
		if (rst_i) tx_pend_r <= 1'b0;
		else if (wr && idx == IDX_DATA) tx_pend_r <= 1'b1;
		else if (tx_take_i) tx_pend_r <= 1'b0;
	end
	assign tx_data_o  = tx_store_r;
	assign tx_valid_o = tx_pend_r;

	// status flags; a hardware set wins over the software clear
	logic clr_rx;
	logic clr_tx;
	assign clr_rx = armed_r && rd && idx == IDX_DATA;
	assign clr_tx = armed_r && wr && idx == IDX_DATA;
	// a character that meets the clearing read is stored, not lost
	assign rx_load = rx_i.valid && (!rxf_r || clr_rx);
	assign rx_over = rx_i.valid && !rx_load;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_r <= 1'b0;
		end else if (req && hit_status) begin
			armed_r <= 1'b1;
		end else if (clr_rx || clr_tx) begin
			armed_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txe_r <= STATUS_RST[ST_TXE];
		end else if (tx_take_i) begin
			txe_r <= 1'b1;
		end else if (wr && hit_data) begin
			txe_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tc_r <= STATUS_RST[ST_TC];
		end else if (tx_done_i) begin
			tc_r <= 1'b1;
		end else if (clr_tx) begin
			tc_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxf_r <= STATUS_RST[ST_RXF];
		end else if (rx_load) begin
			rxf_r <= 1'b1;
		end else if (clr_rx) begin
			rxf_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_r <= STATUS_RST[ST_OR];
		end else if (rx_over) begin
			ovr_r <= 1'b1;
		end else if (clr_rx) begin
			ovr_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nf_r <= STATUS_RST[ST_NF];
			fe_r <= STATUS_RST[ST_FE];
		end else if (rx_load) begin
			nf_r <= rx_i.noise;
			fe_r <= rx_i.frame;
		end else if (clr_rx) begin
			nf_r <= 1'b0;
			fe_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_r <= STATUS_RST[ST_IDLE];
		end else if (rx_i.idle) begin
			idle_r <= 1'b1;
		end else if (clr_rx) begin
			idle_r <= 1'b0;
		end
	end

	always_comb begin
		status          = '0;
		status[ST_TXE]  = txe_r;
		status[ST_TC]   = tc_r;
		status[ST_RXF]  = rxf_r;
		status[ST_IDLE] = idle_r;
		status[ST_OR]   = ovr_r;
		status[ST_NF]   = nf_r;
		status[ST_FE]   = fe_r;
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	assign ev[EV_RX]   = rx_i.valid;
	assign ev[EV_TXE]  = tx_take_i;
	assign ev[EV_TC]   = tx_done_i;
	assign ev[EV_OR]   = rx_over;
	assign ev[EV_IDLE] = rx_i.idle;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_st_r <= '0;
			irq_o    <= 1'b0;
		end else begin
			if (wr && idx == IDX_IRQ_CLR)
				irq_st_r <= (irq_st_r & ~dat_i[EV_W-1:0]) | ev;
			else
				irq_st_r <= irq_st_r | ev;
			irq_o <= |(irq_st_r & irq_en_r);
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) dat_o <= '0;
		else if (rd) begin
			case (idx)
				IDX_STATUS:  dat_o <= {24'h0, status};
				IDX_DATA:    dat_o <= {24'h0, rx_store_r};
				IDX_BAUD:    dat_o <= {24'h0, baud_r};
				IDX_CTL1:    dat_o <= {24'h0, ctl1_r};
				IDX_CTL2:    dat_o <= {24'h0, ctl2_r};
				IDX_ERX:     dat_o <= {24'h0, erx_r};
				IDX_ETX:     dat_o <= {24'h0, etx_r};
				IDX_IRQ_EN:  dat_o <= {27'h0, irq_en_r};
				IDX_IRQ_ST:  dat_o <= {27'h0, irq_st_r};
				default:     dat_o <= 32'h0;
			endcase
		end
	end

	// ************************************************************
	// rate chains, one per direction
	// ************************************************************
	logic [3:0] fs_max;
	always_comb begin
		case (baud_r[FS_LSB+:2])
			2'b00:   fs_max = FS_F0;
			2'b01:   fs_max = FS_F1;
			2'b10:   fs_max = FS_F2;
			default: fs_max = FS_F3;
		endcase
	end

	logic [1:0] tick_out;
	generate
		for (genvar d = 0; d < 2; d++) begin : g_chain
			logic [3:0] fs_r;
			logic [6:0] pw_r;
			logic [3:0] fx_r;
			logic [7:0] ex_r;
			logic [2:0] code;
			logic [7:0] ext;
			logic       fs_end;
			logic       pw_end;
			logic       fx_end;
			logic       tk_r;
			// d 0 is transmit, d 1 is receive
			assign code = d == 0 ? baud_r[TX_LSB+:3] : baud_r[RX_LSB+:3];
			assign ext  = d == 0 ? etx_r : erx_r;
			assign fs_end = fs_r == fs_max;
			// conventional: power-of-two divisor after first stage; extended bypasses both
			assign pw_end = ext != ZERO_RST || pw_r == 7'((8'h1 << code) - 8'h1);
			assign fx_end = fx_r == FIXED_MAX;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					fs_r <= '0;
					pw_r <= '0;
					fx_r <= '0;
					ex_r <= '0;
					tk_r <= 1'b0;
				end else begin
					tk_r <= 1'b0;
					if (ext != ZERO_RST || fs_end) fs_r <= '0;
					else fs_r <= fs_r + 4'h1;
					if (ext != ZERO_RST || fs_end) begin
						pw_r <= pw_end ? 7'h0 : pw_r + 7'h1;
						if (pw_end) begin
							fx_r <= fx_end ? 4'h0 : fx_r + 4'h1;
							if (fx_end) begin
								if (ext == ZERO_RST) tk_r <= 1'b1;
								else if (ex_r >= ext - 8'h1) begin
									ex_r <= '0;
									tk_r <= 1'b1;
								end else ex_r <= ex_r + 8'h1;
							end
						end
					end
				end
			end
			assign tick_out[d] = tk_r;
		end
	endgenerate
	assign tx_tick_o = tick_out[0];
	assign rx_tick_o = tick_out[1];
endmodule

// file: asu_regs_properties.sv
// concurrent checks on the async serial unit register block ports
`timescale 1ns/100ps
module asu_chk
	import asu_pkg::*;
(
	// clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// bus
	input wire logic              cyc_i,
	input wire logic              stb_i,
	input wire logic              we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0]        sel_i,
	input wire logic [31:0]       dat_i,
	input wire logic [31:0]       dat_o,
	input wire logic              ack_o,
	// shifter side and outputs
	input wire logic [7:0]        tx_data_o,
	input wire logic              tx_valid_o,
	input wire logic              tx_tick_o,
	input wire logic              rx_tick_o,
	input wire logic              irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****************
	// properties
	// ****************
	wire take = cyc_i && stb_i && !ack_o;
	wire wr_dat = take && we_i && sel_i[0] && adr_i[9:2] == IDX_DATA;
	property p_ack; take |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack1; ack_o |=> !ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("long ack");
	property p_txw; wr_dat |=> tx_data_o == $past(dat_i[7:0]) && tx_valid_o; endproperty
	a_txw: assert property (p_txw) else $error("tx store");
	property p_txh; !wr_dat |=> $stable(tx_data_o); endproperty
	a_txh: assert property (p_txh) else $error("tx moved");
	property p_rdh; take && we_i |=> $stable(dat_o); endproperty
	a_rdh: assert property (p_rdh) else $error("read moved");
	property p_txt; tx_tick_o |=> !tx_tick_o [*8]; endproperty
	a_txt: assert property (p_txt) else $error("tx tick");
	property p_rxt; rx_tick_o |=> !rx_tick_o [*8]; endproperty
	a_rxt: assert property (p_rxt) else $error("rx tick");
	property p_irq; $fell(rst_i) |-> !irq_o; endproperty
	a_irq: assert property (p_irq) else $error("irq at reset");
endmodule

bind asu_regs asu_chk u_chk(.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
	.dat_o, .ack_o, .tx_data_o, .tx_valid_o, .tx_tick_o, .rx_tick_o, .irq_o);

// file: asu_far.sv
// far-side shifter model: takes transmit bytes, delivers received characters
`timescale 1ns/100ps
module asu_far
	import asu_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic [7:0] dly_i,
	output logic            tx_take_o,
	output logic            tx_done_o,
	output logic [7:0]      got_o,
	output asu_rx_t         rx_o
);
	int cnt = 0;
	initial rx_o = '0;
	always @(posedge clk_i) begin
		tx_take_o <= 1'b0;
		tx_done_o <= 1'b0;
		if (rst_i) begin
			cnt <= 0;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			tx_done_o <= cnt == 1;
		end else if (tx_valid_i && !tx_take_o) begin
			got_o <= tx_data_i;
			tx_take_o <= 1'b1;
			cnt <= dly_i + 1;
		end
	end
	// between characters the data lines show a changed pattern, never the last value
	task send(input logic [7:0] d, input logic n);
		@(posedge clk_i);
		rx_o <= {1'b1, d, n, 3'h0};
		@(posedge clk_i);
		rx_o <= {1'b0, ~d, 4'h0};
	endtask
endmodule

// file: tb.sv
// self-checking bench for the async serial unit register block
`timescale 1ns/100ps
module tb;
	import asu_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [9:0]  adr_i = 10'h0;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	logic [7:0]  tx_data_o, got, d, bd, dly = 8'h1;
	logic        ack_o, tx_valid_o, tx_take_i, tx_done_i, tx_tick_o, rx_tick_o, irq_o;
	asu_rx_t     rx_i;
	int          failures = 0, num_checks = 0, seed = 32'hd1e6, n, pt, pr, tw;
	logic [7:0]  ri [7] = '{IDX_STATUS, IDX_BAUD, IDX_CTL2, IDX_ERX, IDX_ETX, IDX_IRQ_ST, IDX_RX_IN};
	always #4 clk_i = ~clk_i;
	asu_regs DUT(.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.tx_data_o, .tx_valid_o, .tx_take_i, .tx_done_i, .rx_i, .tx_tick_o, .rx_tick_o, .irq_o);
	asu_far u_far(.clk_i, .rst_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .dly_i(dly),
		.tx_take_o(tx_take_i), .tx_done_o(tx_done_i), .got_o(got), .rx_o(rx_i));
	// ****************
	// tasks
	// ****************
	task wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	// request held until ack is sampled high, then released for at least a cycle
	task wb(input logic w, input logic [7:0] ix, input logic [7:0] v);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h1};
		adr_i <= {ix, 2'b00};
		dat_i <= {24'h0, v};
		n = 0;
		do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		if (n >= 20) begin failures++; wrap_up; end
	endtask
	// skips the first two intervals, which may be cut short by a rate change
	task per_of(input logic tx, output int c);
		int k;
		c = 0;
		k = 0;
		while (k < 3 && c < 20000) begin
			@(posedge clk_i);
			c++;
			if ((tx ? tx_tick_o : rx_tick_o) === 1'b1) begin k++; if (k < 3) c = 0; end
		end
		if (c >= 20000) begin failures++; wrap_up; end
	endtask
	function int expp(input logic [7:0] b, input logic [7:0] e, input int sh);
		int f;
		f = b[7:6] == 2'h0 ? 1 : b[7:6] == 2'h1 ? 3 : b[7:6] == 2'h2 ? 4 : 13;
		return e != 8'h0 ? 16 * e : 16 * f * (1 << ((b >> sh) & 8'h7));
	endfunction
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			wb(1'b0, ri[i], 8'h0);
			chk("reset", q, {24'h0, i == 0 ? STATUS_RST : ZERO_RST});
		end
		for (int i = 0; i < 2; i++) begin
			dly = i ? 8'h28 : 8'h01;
			d = 8'($random(seed));
			wb(1'b1, IDX_IRQ_EN, {7'h0, ~i[0]});
			wb(1'b0, IDX_STATUS, 8'h0);
			wb(1'b1, IDX_DATA, d);
			chk("txdata", tx_data_o, d);
			wb(1'b0, IDX_STATUS, 8'h0);
			if (i) chk("tc", q[ST_TC], 0);
			// poll the sticky flag; the done pulse itself may already be gone
			tw = 0;
			do begin wb(1'b0, IDX_STATUS, 8'h0); tw++; end while (q[ST_TC] !== 1'b1 && tw < 100);
			if (tw >= 100) begin failures++; wrap_up; end
			chk("tcset", q[ST_TC], 1);
			chk("got", got, d);
			u_far.send(~d, i[0]);
			if (i) u_far.send(d, i[0]);
			wb(1'b1, IDX_DATA, d ^ 8'h5a);
			wb(1'b0, IDX_STATUS, 8'h0);
			chk("rxf", q[ST_RXF], 1);
			chk("ovr", q[ST_OR], i);
			wb(1'b0, IDX_DATA, 8'h0);
			chk("rxdata", q, {24'h0, ~d});
			wb(1'b0, IDX_CTL1, 8'h0);
			chk("ninth", q[CTL1_R9], i);
			wb(1'b0, IDX_STATUS, 8'h0);
			chk("rxclr", q[5:1], 0);
			wb(1'b0, IDX_IRQ_ST, 8'h0);
			chk("irqst", q[EV_RX], 1);
			chk("irq", irq_o, !i);
			wb(1'b1, IDX_IRQ_CLR, 8'h01);
			wb(1'b0, IDX_IRQ_ST, 8'h0);
			chk("irqclr", q[EV_RX], 0);
			chk("irqoff", irq_o, 0);
		end
		for (int i = 0; i < 6; i++) begin
			bd = i == 4 ? 8'h3f : {i[1:0], 6'($random(seed)) & 6'h1b};
			wb(1'b1, IDX_BAUD, bd);
			wb(1'b1, IDX_ERX, i == 4 ? 8'h01 : 8'h00);
			wb(1'b1, IDX_ETX, i == 5 ? 8'hff : 8'h00);
			wb(1'b0, IDX_BAUD, 8'h0);
			chk("baud", q, {24'h0, bd});
			per_of(1'b1, pt);
			chk("txper", pt, expp(bd, i == 5 ? 8'hff : 8'h00, TX_LSB));
			per_of(1'b0, pr);
			chk("rxper", pr, expp(bd, i == 4 ? 8'h01 : 8'h00, RX_LSB));
		end
		wrap_up;
	end
endmodule
